// ===== rtl/serial_irq_pkg.sv
// Shared constants for the dual-channel serial interrupt and register logic.
package serial_irq_pkg;
  localparam int CHANNELS = 2;
  // Register port address bits.
  localparam int ADDR_CTRL_BIT = 0;
  localparam int ADDR_CHAN_BIT = 1;
  // Pointer values of write and read registers.
  localparam logic [2:0] PTR_RESET     = 3'h0;
  localparam logic [2:0] WREG_CMD      = 3'h0;
  localparam logic [2:0] WREG_IRQ_MODE = 3'h1;
  localparam logic [2:0] WREG_VECTOR   = 3'h2;
  localparam logic [2:0] WREG_RX_CTRL  = 3'h3;
  localparam logic [2:0] WREG_TX_CTRL  = 3'h5;
  localparam logic [2:0] RREG_MAIN     = 3'h0;
  localparam logic [2:0] RREG_RX_ERR   = 3'h1;
  localparam logic [2:0] RREG_VECTOR   = 3'h2;
  // Basic command field of the command register.
  localparam int         CMD_LSB        = 3;
  localparam int         PTR_MSB        = 2;
  localparam logic [2:0] CMD_RST_EXT    = 3'h2;
  localparam logic [2:0] CMD_CHAN_RESET = 3'h3;
  localparam logic [2:0] CMD_RST_TX     = 3'h5;
  localparam logic [2:0] CMD_ERR_RESET  = 3'h6;
  localparam logic [2:0] CMD_RETURN_FROM_IRQ_OPCODE       = 3'h7;
  // Interrupt mode register bits and enables in the rx and tx control registers.
  localparam int IRQ_EXT_EN_BIT = 0;
  localparam int IRQ_TX_EN_BIT  = 1;
  localparam int IRQ_SAV_BIT    = 2;
  localparam int IRQ_RXMODE_LSB = 3;
  localparam int RX_ENABLE_BIT  = 0;
  localparam int TX_ENABLE_BIT  = 3;
  // Values after reset.
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] VECTOR_RST = 8'h00;
  // Vector modification: code bits sit at vector bits 3..1.
  localparam logic [1:0] SUB_TX    = 2'h0;
  localparam logic [1:0] SUB_EXT   = 2'h1;
  localparam logic [1:0] SUB_RX    = 2'h2;
  localparam logic [1:0] SUB_SPEC  = 2'h3;
  localparam logic [2:0] CODE_IDLE = 3'h3;
  // Two-byte return opcode watched on the data bus.
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_FIRST  = 8'hED;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_SECOND = 8'h4D;
  // Delay line depths; pin edge to request output is depth plus five cycles.
  localparam int TX_EDGE_DEPTH = 2;
  localparam int RX_EDGE_DEPTH = 7;
endpackage

// ===== rtl/bitclk_edge_delay.sv
// Bit clock pin synchroniser, edge detector and fixed delay line.
`timescale 1ns/1ps
module bitclk_edge_delay #(
  parameter int DEPTH  = 2,
  parameter bit RISING = 1'b1
) (
  // Clock and synchronised reset.
  input  wire logic mclk,
  input  wire logic rstSyncN,
  // Bit clock pin and its delayed edge event.
  input  wire logic bitClock,
  output logic      edgeEvt
);
  typedef struct packed {
    logic [2:0]       sy;
    logic [DEPTH-1:0] line;
  } edge_st_t;

  edge_st_t st_r;
  edge_st_t st_nxt;
  logic     edgeNow;

  // The edge detector reads the second and third stages, never the first.
  assign edgeNow = RISING ? (st_r.sy[1] & ~st_r.sy[2]) : (~st_r.sy[1] & st_r.sy[2]);

  // Shift the pin through the synchroniser and the edge through the delay line.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sy   = {st_r.sy[1:0], bitClock};
    st_nxt.line = DEPTH'({st_r.line, edgeNow});
  end

  // State register.
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edgeEvt = st_r.line[DEPTH-1];

  a_edge_latency: assert property ( // R22 R23
    @(posedge mclk) disable iff (!rstSyncN) edgeNow |-> ##DEPTH edgeEvt)
    else $error("Bit clock edge not delivered after the fixed delay.");
endmodule

// ===== rtl/irq_priority.sv
// Fixed internal priority resolver producing the vector status code.
`timescale 1ns/1ps
module irq_priority (
  // Pending sources per channel, index 0 is channel A.
  input  wire logic [1:0] rxPend,
  input  wire logic [1:0] specPend,
  input  wire logic [1:0] txPend,
  input  wire logic [1:0] extPend,
  // Resolved request and its code.
  output logic            anyPend,
  output logic [2:0]      pendCode
);
  import serial_irq_pkg::*;

  // Walk from lowest to highest priority so the later match wins.
  always_comb begin
    anyPend  = 1'b0;
    pendCode = CODE_IDLE;
    for (int ch = CHANNELS - 1; ch >= 0; ch--) begin
      if (extPend[ch]) begin
        anyPend  = 1'b1;
        pendCode = {ch == 0, SUB_EXT};
      end
      if (txPend[ch]) begin
        anyPend  = 1'b1;
        pendCode = {ch == 0, SUB_TX};
      end
      if (rxPend[ch] || specPend[ch]) begin
        anyPend  = 1'b1;
        pendCode = {ch == 0, specPend[ch] ? SUB_SPEC : SUB_RX};
      end
    end
  end
endmodule

// ===== rtl/serial_irq_ctrl.sv
// Host interface of a dual serial controller: daisy chain, vectors, register pointers.
// Operation
// R01 - Device requests service by pulling its active-low request output low.
// R02 - Host acknowledges with opcode fetch and I/O request both low.
// R03 - Highest-priority peripheral has its chain enable input tied high.
// R04 - Idle and not under service: chain output follows chain input.
// R05 - Pending or under service: chain output driven low.
// R06 - Interrupt status held still while opcode fetch is low.
// R07 - During acknowledge the vector is driven only with chain input high.
// R08 - Supplying the vector sets the under-service latch until return.
// R09 - Return opcode pair seen on fetches clears the under-service latch.
// R10 - Return command to channel A command register acts like the opcode.
// R11 - Other write registers take a pointer byte then the control word.
// R12 - Low three pointer bits select the register of the next access.
// R13 - Basic command field acts from a single write.
// R14 - Any reset returns the pointer to the command register.
// R15 - Host sets no pointer in the same write as channel reset.
// R16 - Status reads other than main status need a pointer write first.
// R17 - Channel select and control/data select address the registers.
// R18 - Vector write and modified vector read exist in channel B only.
// R19 - All special receive error flags sit in one status register.
// R20 - System clock runs at least five times the serial bit rate.
// R21 - Reset input held active at least one clock cycle.
// R22 - Request or ready follows a falling tx bit clock by 5 to 9 cycles.
// R23 - Request or ready follows a rising rx bit clock by 10 to 13 cycles.
// R24 - Priority: A over B; receive, transmit, external status within a channel.
// R25 - Status-affects-vector encodes the highest pending condition into the vector.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module serial_irq_ctrl (
  // Clock and reset.
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  // Register port: bit 1 selects channel B, bit 0 selects control.
  input  wire logic [1:0]                         regAddr,
  input  wire logic [7:0]                         regWrData,
  input  wire logic                               regWrStb,
  input  wire logic                               regRdStb,
  output logic [7:0]                              regRdData,
  // Host bus and daisy chain pins.
  input  wire logic                               opcodeFetchN,
  input  wire logic                               ioRequestN,
  input  wire logic                               chainEnableIn,
  output logic                                    chainEnableOut,
  output logic                                    irqReqN,
  input  wire logic [7:0]                         busDataIn,
  output logic [7:0]                              busDataOut,
  output logic                                    busDataOe,
  // Serial bit clock pins, index 0 is channel A.
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] txBitClock,
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] rxBitClock,
  // Channel datapath status from same-clock logic.
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] txEmpty,
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] rxAvail,
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] [2:0] rxErrPulse,
  input  wire logic [serial_irq_pkg::CHANNELS-1:0] extChange,
  // Ready outputs, low while a channel wants a transfer.
  output logic [serial_irq_pkg::CHANNELS-1:0]     readyN
);
  import serial_irq_pkg::*;

  typedef struct packed {
    logic [1:0]                 m1Sy;
    logic [1:0]                 ioSy;
    logic [1:0]                 ieiSy;
    logic [7:0]                 dSy0;
    logic [7:0]                 dSy1;
    logic                       m1Q;
    logic                       intaQ;
    logic                       ackSeen;
    logic [7:0]                 fetch;
    logic                       sawEd;
    logic [CHANNELS-1:0] [2:0]  ptr;
    logic [CHANNELS-1:0] [7:0]  mode;
    logic [CHANNELS-1:0]        rxEn;
    logic [CHANNELS-1:0]        txEn;
    logic [CHANNELS-1:0]        rxIp;
    logic [CHANNELS-1:0]        txIp;
    logic [CHANNELS-1:0]        exIp;
    logic [CHANNELS-1:0] [2:0]  err;
    logic [7:0]                 vec;
    logic                       pendFrz;
    logic [2:0]                 codeFrz;
    logic                       ius;
    logic                       vecOe;
    logic [7:0]                 vecOut;
    logic                       irqN;
    logic [CHANNELS-1:0]        rdyPre;
    logic [CHANNELS-1:0]        rdyN;
    logic [7:0]                 rd;
  } ctrl_st_t;

  ctrl_st_t            st_r;
  ctrl_st_t            st_nxt;
  logic [1:0]          rstPipe_r;
  logic                rstSyncN;
  logic                m1S;
  logic                ioS;
  logic                ieiS;
  logic                inta;
  logic                intaRise;
  logic                m1Rise;
  logic                retiBus;
  logic                retiCmd;
  logic                chSel;
  logic                ctlSel;
  logic [2:0]          cmdNow;
  logic [CHANNELS-1:0] txEvt;
  logic [CHANNELS-1:0] rxEvt;
  logic [CHANNELS-1:0] specPend;
  logic                anyPend;
  logic [2:0]          pendCode;
  logic [7:0]          vecMod;
  logic [7:0]          rdMux;

  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_r[1];

  // Synchronised host pins and decoded bus cycles.
  assign m1S      = st_r.m1Sy[1];
  assign ioS      = st_r.ioSy[1];
  assign ieiS     = st_r.ieiSy[1];
  // R02 acknowledge decode
  assign inta     = ~m1S & ~ioS;
  assign intaRise = inta & ~st_r.intaQ;
  assign m1Rise   = m1S & ~st_r.m1Q;
  // R09 return opcode pair
  assign retiBus  = m1Rise & ~st_r.ackSeen & st_r.sawEd & (st_r.fetch == RETURN_FROM_IRQ_OPCODE_SECOND);

  // R17 address decode
  assign chSel  = regAddr[ADDR_CHAN_BIT];
  assign ctlSel = regAddr[ADDR_CTRL_BIT];
  assign cmdNow = regWrData[CMD_LSB +: 3];

  // Bit clock edge delays and special receive condition per channel.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    // R22 tx edge delay
    bitclk_edge_delay #(
      .DEPTH  (TX_EDGE_DEPTH),
      .RISING (1'b0)
    ) u_txEdge (
      .mclk     (mclk),
      .rstSyncN (rstSyncN),
      .bitClock (txBitClock[ch]),
      .edgeEvt  (txEvt[ch])
    );
    // R23 rx edge delay
    bitclk_edge_delay #(
      .DEPTH  (RX_EDGE_DEPTH),
      .RISING (1'b1)
    ) u_rxEdge (
      .mclk     (mclk),
      .rstSyncN (rstSyncN),
      .bitClock (rxBitClock[ch]),
      .edgeEvt  (rxEvt[ch])
    );
    assign specPend[ch] = (|st_r.err[ch]) & st_r.rxEn[ch]
                          & (st_r.mode[ch][IRQ_RXMODE_LSB +: 2] != 2'b00);
  end

  // R24 fixed internal priority
  irq_priority u_prio (
    .rxPend   (st_r.rxIp),
    .specPend (specPend),
    .txPend   (st_r.txIp),
    .extPend  (st_r.exIp),
    .anyPend  (anyPend),
    .pendCode (pendCode)
  );

  // R25 status modifies vector bits 3..1 when enabled in channel B.
  assign vecMod = st_r.mode[1][IRQ_SAV_BIT] ? {st_r.vec[7:4], st_r.codeFrz, st_r.vec[0]}
                                            : st_r.vec;

  // Read multiplexer; the pointer picks the status register.
  always_comb begin
    rdMux = 8'h00;
    if (ctlSel) begin
      unique case (st_r.ptr[chSel])
        RREG_MAIN: begin
          rdMux = {4'h0, st_r.exIp[chSel], txEmpty[chSel], st_r.pendFrz & ~chSel,
                   rxAvail[chSel]};
        end
        // R19 all error flags together
        RREG_RX_ERR: begin
          rdMux = {1'b0, st_r.err[chSel], 3'b000, txEmpty[chSel]};
        end
        // R18 vector readback in channel B
        RREG_VECTOR: begin
          rdMux = chSel ? vecMod : 8'h00;
        end
        default: begin
          rdMux = 8'h00;
        end
      endcase
    end
  end

  // Next state: synchronisers, register writes, events, chain and acknowledge.
  always_comb begin
    st_nxt       = st_r;
    retiCmd      = 1'b0;
    st_nxt.m1Sy  = {st_r.m1Sy[0], opcodeFetchN};
    st_nxt.ioSy  = {st_r.ioSy[0], ioRequestN};
    st_nxt.ieiSy = {st_r.ieiSy[0], chainEnableIn};
    st_nxt.dSy0  = busDataIn;
    st_nxt.dSy1  = st_r.dSy0;
    st_nxt.m1Q   = m1S;
    st_nxt.intaQ = inta;
    // Track the last byte of each opcode fetch, skipping acknowledge cycles.
    if (!m1S && ioS) begin
      st_nxt.fetch = st_r.dSy1;
    end
    if (inta) begin
      st_nxt.ackSeen = 1'b1;
    end
    if (m1Rise) begin
      st_nxt.ackSeen = 1'b0;
      st_nxt.sawEd   = ~st_r.ackSeen & (st_r.fetch == RETURN_FROM_IRQ_OPCODE_FIRST);
    end
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (regWrStb && ctlSel && (int'(chSel) == ch)) begin
        if (st_r.ptr[ch] == WREG_CMD) begin
          // R12 pointer from low bits
          st_nxt.ptr[ch] = regWrData[PTR_MSB:0];
          // R13 single write command
          unique case (cmdNow)
            CMD_RST_EXT: begin
              st_nxt.exIp[ch] = 1'b0;
            end
            // R14 channel reset clears pointer
            CMD_CHAN_RESET: begin
              st_nxt.ptr[ch]  = PTR_RESET;
              st_nxt.mode[ch] = MODE_RST;
              st_nxt.rxEn[ch] = 1'b0;
              st_nxt.txEn[ch] = 1'b0;
              st_nxt.rxIp[ch] = 1'b0;
              st_nxt.txIp[ch] = 1'b0;
              st_nxt.exIp[ch] = 1'b0;
              st_nxt.err[ch]  = 3'b000;
            end
            CMD_RST_TX: begin
              st_nxt.txIp[ch] = 1'b0;
            end
            CMD_ERR_RESET: begin
              st_nxt.err[ch] = 3'b000;
            end
            // R10 return command on channel A
            CMD_RETURN_FROM_IRQ_OPCODE: begin
              retiCmd = (ch == 0);
            end
            default: begin
              retiCmd = 1'b0;
            end
          endcase
        end else begin
          // R11 second byte loads the pointed register
          unique case (st_r.ptr[ch])
            WREG_IRQ_MODE: begin
              st_nxt.mode[ch] = regWrData;
            end
            // R18 vector register in channel B only
            WREG_VECTOR: begin
              if (ch == 1) begin
                st_nxt.vec = regWrData;
              end
            end
            WREG_RX_CTRL: begin
              st_nxt.rxEn[ch] = regWrData[RX_ENABLE_BIT];
            end
            WREG_TX_CTRL: begin
              st_nxt.txEn[ch] = regWrData[TX_ENABLE_BIT];
            end
            default: begin
              st_nxt.ptr[ch] = PTR_RESET;
            end
          endcase
          st_nxt.ptr[ch] = PTR_RESET;
        end
      end
      // R16 pointed read returns pointer to zero
      if (regRdStb && ctlSel && (int'(chSel) == ch)) begin
        st_nxt.ptr[ch] = PTR_RESET;
      end
      // Loading the transmit data register clears its pending request.
      if (regWrStb && !ctlSel && (int'(chSel) == ch)) begin
        st_nxt.txIp[ch] = 1'b0;
      end
      // Events are applied after clears so a simultaneous set wins.
      st_nxt.rxIp[ch] = (st_nxt.rxIp[ch] & rxAvail[ch])
                        | (rxEvt[ch] & rxAvail[ch] & st_r.rxEn[ch]
                           & (st_r.mode[ch][IRQ_RXMODE_LSB +: 2] != 2'b00));
      if (txEvt[ch] && txEmpty[ch] && st_r.txEn[ch] && st_r.mode[ch][IRQ_TX_EN_BIT]) begin
        st_nxt.txIp[ch] = 1'b1;
      end
      if (extChange[ch] && st_r.mode[ch][IRQ_EXT_EN_BIT]) begin
        st_nxt.exIp[ch] = 1'b1;
      end
      st_nxt.err[ch] = st_nxt.err[ch] | rxErrPulse[ch];
    end
    // R06 status frozen during opcode fetch
    if (m1S) begin
      st_nxt.pendFrz = anyPend;
      st_nxt.codeFrz = pendCode;
    end
    if (!inta) begin
      st_nxt.vecOe = 1'b0;
    end
    // R09 return clears service latch
    if (retiBus || retiCmd) begin
      st_nxt.ius = 1'b0;
    end
    // R07 vector only with chain input high
    if (intaRise && ieiS && st_r.pendFrz && !st_r.ius) begin
      st_nxt.vecOe  = 1'b1;
      st_nxt.vecOut = vecMod;
      // R08 set service latch
      st_nxt.ius    = 1'b1;
    end
    // R01 request output
    st_nxt.irqN   = ~(st_r.pendFrz & ~st_r.ius & ieiS);
    st_nxt.rdyPre = st_r.rxIp | st_r.txIp;
    st_nxt.rdyN   = ~st_r.rdyPre;
    st_nxt.rd     = regRdStb ? rdMux : st_r.rd;
  end

  // State register; active-low pins idle high after reset.
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r      <= '0;
      st_r.m1Sy <= 2'b11;
      st_r.ioSy <= 2'b11;
      st_r.m1Q  <= 1'b1;
      st_r.vec  <= VECTOR_RST;
      st_r.irqN <= 1'b1;
      st_r.rdyN <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // R04 R05 daisy chain output
  assign chainEnableOut = ieiS & ~(st_r.pendFrz | st_r.ius);
  assign irqReqN        = st_r.irqN;
  assign busDataOut     = st_r.vecOut;
  assign busDataOe      = st_r.vecOe;
  assign readyN         = st_r.rdyN;
  assign regRdData      = st_r.rd;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstSyncN);

  a_irq_request: assert property ( // R01
    st_r.pendFrz && !st_r.ius && ieiS |=> !irqReqN)
    else $error("Pending request did not pull the request output low.");
  a_chain_follow: assert property ( // R04
    !st_r.pendFrz && !st_r.ius |-> chainEnableOut == ieiS)
    else $error("Idle device does not pass the chain enable.");
  a_chain_block: assert property ( // R05
    st_r.pendFrz || st_r.ius |-> !chainEnableOut)
    else $error("Busy device did not block the chain.");
  a_status_frozen: assert property ( // R06
    !m1S |=> $stable(st_r.pendFrz) && $stable(st_r.codeFrz))
    else $error("Interrupt status changed during opcode fetch.");
  a_vector_gate: assert property ( // R07
    $rose(busDataOe) |-> $past(ieiS) && $past(inta) && $past(st_r.pendFrz))
    else $error("Vector driven without chain enable or acknowledge.");
  a_latch_set: assert property ( // R08
    $rose(busDataOe) |-> $rose(st_r.ius) && busDataOut == $past(vecMod))
    else $error("Vector cycle did not set the service latch.");
  a_bus_return: assert property ( // R09
    retiBus && st_r.ius |=> !st_r.ius)
    else $error("Return opcode pair did not clear the service latch.");
  a_cmd_return: assert property ( // R10
    regWrStb && ctlSel && !chSel && st_r.ptr[0] == WREG_CMD && cmdNow == CMD_RETURN_FROM_IRQ_OPCODE
    && st_r.ius |=> !st_r.ius)
    else $error("Return command did not clear the service latch.");
  a_ptr_return: assert property ( // R11
    regWrStb && ctlSel && st_r.ptr[chSel] != WREG_CMD |=> st_r.ptr[$past(chSel)] == PTR_RESET)
    else $error("Pointer did not return to zero after the control word.");
  a_ptr_load: assert property ( // R12
    regWrStb && ctlSel && st_r.ptr[chSel] == WREG_CMD && cmdNow != CMD_CHAN_RESET
    |=> st_r.ptr[$past(chSel)] == $past(regWrData[PTR_MSB:0]))
    else $error("Pointer byte not loaded from the low bits.");
  a_reset_ptr: assert property ( // R14
    regWrStb && ctlSel && st_r.ptr[chSel] == WREG_CMD && cmdNow == CMD_CHAN_RESET
    |=> st_r.ptr[$past(chSel)] == PTR_RESET)
    else $error("Channel reset left the pointer set.");
  a_read_data: assert property ( // R16
    regRdStb |=> regRdData == $past(rdMux))
    else $error("Read data not the addressed register.");

  c_ack_cycle: cover property ($rose(busDataOe));
  c_sav_vector: cover property ($rose(busDataOe) && st_r.mode[1][IRQ_SAV_BIT]);
  c_bus_return: cover property (retiBus && st_r.ius);
  c_err_read: cover property (regRdStb && ctlSel && st_r.ptr[chSel] == RREG_RX_ERR);
endmodule

// ===== tb/host_bus_model.sv
// Host processor model: acknowledge cycles and return opcode fetches.
`timescale 1ns/1ps
module host_bus_model (
  // Clock.
  input  wire logic       mclk,
  // Device side of the host data bus.
  input  wire logic [7:0] busDataOut,
  input  wire logic       busDataOe,
  // Host strobes and the resolved bus.
  output logic            opcodeFetchN,
  output logic            ioRequestN,
  output logic [7:0]      busDataIn
);
  logic [7:0] hostData;

  // The wire carries the device vector while it drives, else the host byte.
  assign busDataIn = busDataOe ? busDataOut : hostData;

  // Idle bus: strobes high, host byte is a filler pattern.
  initial begin
    opcodeFetchN = 1'b1;
    ioRequestN   = 1'b1;
    hostData     = 8'h55;
  end

  // acknowledge: both strobes low together until two cycles after the vector shows, at most ten cycles.
  task automatic ack(output logic gotOe, output logic [7:0] vec);
    @(posedge mclk);
    opcodeFetchN <= 1'b0;
    ioRequestN   <= 1'b0;
    repeat (8) begin
      @(posedge mclk);
      if (busDataOe === 1'b1) break;
    end
    gotOe = busDataOe;
    vec   = busDataOut;
    repeat (2) @(posedge mclk);
    opcodeFetchN <= 1'b1;
    ioRequestN   <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // One opcode fetch; the bus shows another value once the fetch ends.
  task automatic fetch(input logic [7:0] b);
    @(posedge mclk);
    opcodeFetchN <= 1'b0;
    hostData     <= b;
    repeat (4) @(posedge mclk);
    opcodeFetchN <= 1'b1;
    hostData     <= ~b;
    repeat (3) @(posedge mclk);
  endtask

  // Two-byte return sequence.
  task automatic return_from_irq_opcode();
    fetch(8'hED);
    fetch(8'h4D);
  endtask
endmodule

// ===== tb/serial_irq_ctrl_bench.sv
// Self-checking bench for the serial interrupt controller.
`timescale 1ns/1ps
module serial_irq_ctrl_bench;
  logic             mclk, rst_n, regWrStb, regRdStb, chainEnableIn, chainEnableOut;
  logic             irqReqN, busDataOe, opcodeFetchN, ioRequestN;
  logic [1:0]       regAddr, txBitClock, rxBitClock, txEmpty, rxAvail, extChange, readyN;
  logic [7:0]       regWrData, regRdData, busDataIn, busDataOut;
  logic [1:0] [2:0] rxErrPulse;
  int               errTotal, cmpCount;

  serial_irq_ctrl DUT (.mclk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .opcodeFetchN, .ioRequestN, .chainEnableIn, .chainEnableOut, .irqReqN,
    .busDataIn, .busDataOut, .busDataOe, .txBitClock, .rxBitClock, .txEmpty, .rxAvail,
    .rxErrPulse, .extChange, .readyN);
  host_bus_model host (.mclk, .busDataOut, .busDataOe, .opcodeFetchN, .ioRequestN,
    .busDataIn);

  // Clock of 40 ns period.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compares one byte and reports a mismatch.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Register port write and read, one-cycle strobes.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrStb  <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask

  // Pointer writes, error status, vector register of channel B.
  task automatic t_regs();
    logic [7:0] d;
    @(posedge mclk);
    rxErrPulse[0] <= 3'b111;
    @(posedge mclk);
    rxErrPulse[0] <= 3'b000;
    rd(2'b01, d);
    chk("pointer after reset", 8'h00, d);
    wr(2'b01, 8'h01);
    rd(2'b01, d);
    chk("error status", 8'h70, d);
    rd(2'b01, d);
    chk("main status", 8'h00, d);
    wr(2'b01, 8'h18);
    wr(2'b01, 8'h01);
    rd(2'b01, d);
    chk("errors after channel reset", 8'h00, d);
    wr(2'b01, 8'h30);
    wr(2'b11, 8'h02);
    wr(2'b11, 8'hA0);
    wr(2'b11, 8'h02);
    rd(2'b11, d);
    chk("vector readback", 8'hA0, d);
    wr(2'b01, 8'h02);
    rd(2'b01, d);
    chk("vector on A", 8'h00, d);
  endtask

  // Pin edge to request latency; rx uses a rising edge, tx a falling one.
  task automatic t_lat(input bit rx, input int lo, input int hi);
    int n;
    @(posedge mclk);
    if (rx) rxBitClock[0] <= 1'b1;
    else txBitClock[0] <= 1'b0;
    n = 0;
    while (n < 20 && irqReqN !== 1'b0) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("latency in range", 8'h01, {7'h00, n >= lo && n <= hi});
    chk("ready low", 8'h00, {7'h00, readyN[0]});
    @(posedge mclk);
  endtask

  // External status change, then its reset command.
  task automatic t_ext();
    logic [7:0] d;
    wr(2'b01, 8'h01);
    wr(2'b01, 8'h0B);
    @(posedge mclk);
    extChange[0] <= 1'b1;
    @(posedge mclk);
    extChange[0] <= 1'b0;
    rd(2'b01, d);
    chk("external pending", 8'h0A, d);
    wr(2'b01, 8'h10);
    rd(2'b01, d);
    chk("external cleared", 8'h00, d);
  endtask

  // Refused and granted acknowledge, service, then return by bus or command.
  task automatic t_irq(input bit viaCmd);
    logic       oe;
    logic [7:0] v;
    txBitClock[0] <= 1'b1;
    txEmpty[0]    <= 1'b1;
    repeat (4) @(posedge mclk);
    t_lat(1'b0, 5, 9);
    chk("chain blocked", 8'h00, {7'h00, chainEnableOut});
    chainEnableIn <= 1'b0;
    host.ack(oe, v);
    chk("refused vector", 8'h00, {7'h00, oe});
    chainEnableIn <= 1'b1;
    repeat (3) @(posedge mclk);
    host.ack(oe, v);
    chk("vector", viaCmd ? 8'hA8 : 8'hA0, oe ? v : 8'hFF);
    chk("request gone", 8'h01, {7'h00, irqReqN});
    txEmpty[0] <= 1'b0;
    if (viaCmd) wr(2'b00, 8'h00);
    else wr(2'b01, 8'h28);
    repeat (3) @(posedge mclk);
    chk("under service", 8'h00, {7'h00, chainEnableOut});
    if (viaCmd) wr(2'b01, 8'h38);
    else host.return_from_irq_opcode();
    repeat (4) @(posedge mclk);
    chk("chain follows", 8'h01, {7'h00, chainEnableOut});
  endtask

  // Watchdog far beyond the few hundred cycles the tests take.
  initial begin
    #300000;
    errTotal++;
    closeOut();
  end

  // reset held four cycles; chain input high as first in chain.
  initial begin
    {rst_n, regWrStb, regRdStb, regAddr, regWrData} = '0;
    {txEmpty, rxAvail, extChange, rxErrPulse} = '0;
    {txBitClock, rxBitClock, chainEnableIn} = {4'b1100, 1'b1};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("idle outputs", 8'h07, {5'h00, irqReqN, readyN});
    t_regs();
    wr(2'b01, 8'h03);
    wr(2'b01, 8'h01);
    wr(2'b01, 8'h01);
    wr(2'b01, 8'h0A);
    wr(2'b01, 8'h05);
    wr(2'b01, 8'h08);
    rxAvail[0] <= 1'b1;
    t_lat(1'b1, 10, 13);
    rxAvail[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("request cleared", 8'h01, {7'h00, irqReqN});
    t_irq(1'b0);
    wr(2'b11, 8'h01);
    wr(2'b11, 8'h04);
    t_irq(1'b1);
    t_ext();
    closeOut();
  end
endmodule
